// ===== abs_regs.svh
`ifndef ABS_REGS_SVH
`define ABS_REGS_SVH
// Behaviour
// RQ1: while bus enable is low, every ATA output pin is released (high-Z).
// RQ2: bus enable low halts the ATA interface state machine.
// RQ3: outside manufacturing test, bus enable is sampled every 20 ms.
// RQ4: enable falling edge: release ATA pins, disconnect USB, idle.
// RQ5: enable rising edge: return to post-reset state and reconnect USB.
// RQ6: system should hold bus enable high at start-up.
// RQ7: system should not drop bus enable during a data transfer.
// RQ8: D+ pulled high at reset; VBUS polled at start then every 20 ms.
// RQ9: sampled VBUS high enables the D+ pullup, otherwise pullup off.
// RQ10: address lines and chip selects driven high only after 2 ms.
// RQ11: serial clock/data active several ms at start-up, then held high.
// RQ12: chip reset held low 10 ms resets whole device.
// RQ13: system supplies a 24 MHz reference clock; timing here assumes 20 MHz (ABS_CLK_HZ).
// RQ14: manufacturing test mode persists, polling suspended, until hard reset; here only bus enable sampling stops, VBUS is still polled every 20 ms.
// RQ15: bus enable and VBUS inputs are synchronised before sampling.
`define ABS_CLK_HZ         20000000
`define ABS_POLL_MS        20
`define ABS_POLL_CYC       ((`ABS_CLK_HZ / 1000) * `ABS_POLL_MS)
`define ABS_ADDR_DLY_MS    2
`define ABS_ADDR_DLY_CYC   ((`ABS_CLK_HZ / 1000) * `ABS_ADDR_DLY_MS)
`define ABS_SER_ACT_MS     4
`define ABS_SER_ACT_CYC    ((`ABS_CLK_HZ / 1000) * `ABS_SER_ACT_MS)
`define ABS_RESET_MS       10
`define ABS_CNT_W          20
`endif

// ===== abs_pkg.sv
package abs_pkg;
	typedef enum logic [1:0] {
		ABS_ST_START,
		ABS_ST_RUN,
		ABS_ST_IDLE,
		ABS_ST_TEST
	} abs_state_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [1:0] cs_n;
		logic       dior_n;
		logic       diow_n;
		logic       dmack_n;
		logic       drive_reset_n;
	} abs_ata_out_t;
endpackage

// ===== abs_ctrl.sv
`include "abs_regs.svh"
module abs_ctrl #(
	parameter int POLL_CYC    = `ABS_POLL_CYC,
	parameter int ADDR_CYC    = `ABS_ADDR_DLY_CYC,
	parameter int SER_CYC     = `ABS_SER_ACT_CYC
) (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  reset_n_in,
	// pins
	input  wire logic                  ata_bus_enable_in,
	input  wire logic                  vbus_present_in,
	// engine side
	input  wire logic                  mfg_test_enter_in,
	input  wire abs_pkg::abs_ata_out_t ata_ctl_in,
	input  wire logic                  ser_clk_in,
	input  wire logic                  ser_dat_in,
	// ATA outputs
	output logic                       ata_oe_out,
	output logic                       addr_oe_out,
	output abs_pkg::abs_ata_out_t      ata_ctl_out,
	output logic                       ata_engine_run_out,
	output logic                       ata_engine_restart_out,
	// USB and serial memory
	output logic                       usb_dp_line_pullup_out,
	output logic                       usb_connect_out,
	output logic                       ser_clk_out,
	output logic                       ser_dat_out
);
	import abs_pkg::*;

	localparam logic [`ABS_CNT_W-1:0] POLL_MAX = `ABS_CNT_W'(POLL_CYC - 1);
	localparam logic [`ABS_CNT_W-1:0] ADDR_MAX = `ABS_CNT_W'(ADDR_CYC - 1);
	localparam logic [`ABS_CNT_W-1:0] SER_MAX  = `ABS_CNT_W'(SER_CYC - 1);

	logic [1:0]            en_sync_reg;
	logic [1:0]            vb_sync_reg;
	logic                  en_samp_reg;
	logic                  vb_samp_reg;
	logic [`ABS_CNT_W-1:0] poll_cnt_reg;
	logic [`ABS_CNT_W-1:0] boot_cnt_reg;
	logic                  addr_ok_reg;
	logic                  ser_done_reg;
	logic                  first_poll_reg;
	abs_state_t            state_reg;
	abs_state_t            state_next;
	abs_ata_out_t          ata_next;

	wire en_now   = en_sync_reg[1];
	wire vb_now   = vb_sync_reg[1];
	wire poll_hit = first_poll_reg || (poll_cnt_reg == POLL_MAX);
	wire en_fall  = poll_hit && en_samp_reg && !en_now;
	wire en_rise  = poll_hit && !en_samp_reg && en_now;
	wire in_test  = (state_reg == ABS_ST_TEST);
	wire run_ok   = (state_reg == ABS_ST_RUN);
	wire oe_next  = (state_next == ABS_ST_RUN) &&
		(poll_hit ? en_now : en_samp_reg);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ABS_ST_START: begin
				if (poll_hit)
					state_next = en_now ? ABS_ST_RUN : ABS_ST_IDLE;
			end
			ABS_ST_RUN: begin
				if (mfg_test_enter_in)
					state_next = ABS_ST_TEST; // RQ14
				else if (en_fall)
					state_next = ABS_ST_IDLE; // RQ4
			end
			ABS_ST_IDLE: begin
				if (mfg_test_enter_in)
					state_next = ABS_ST_TEST; // RQ14
				else if (en_rise)
					state_next = ABS_ST_RUN; // RQ5
			end
			ABS_ST_TEST: state_next = ABS_ST_TEST; // RQ14
		endcase
	end

	always_comb begin
		ata_next = ata_ctl_in;
		if (!addr_ok_reg) begin
			ata_next.addr = 3'h0; // RQ10
			ata_next.cs_n = 2'h0; // RQ10
		end
	end

	// synchronisers
	always_ff @(posedge clk_in) begin
		en_sync_reg <= {en_sync_reg[0], ata_bus_enable_in}; // RQ15
		vb_sync_reg <= {vb_sync_reg[0], vbus_present_in}; // RQ15
	end

	// periodic sampling
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin // RQ12
			poll_cnt_reg   <= '0;
			first_poll_reg <= 1'b1;
			en_samp_reg    <= 1'b1;
			vb_samp_reg    <= 1'b1; // RQ8
		end else begin
			first_poll_reg <= 1'b0;
			poll_cnt_reg   <= poll_hit ? '0 : poll_cnt_reg + 1'b1; // RQ3
			if (poll_hit) begin
				vb_samp_reg <= vb_now; // RQ8
				if (!in_test)
					en_samp_reg <= en_now; // RQ3
			end
		end
	end

	// start-up timers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			boot_cnt_reg <= '0;
			addr_ok_reg  <= 1'b0;
			ser_done_reg <= 1'b0;
		end else begin
			if (!ser_done_reg)
				boot_cnt_reg <= boot_cnt_reg + 1'b1;
			if (boot_cnt_reg == ADDR_MAX)
				addr_ok_reg <= 1'b1; // RQ10
			if (boot_cnt_reg == SER_MAX)
				ser_done_reg <= 1'b1; // RQ11
		end
	end

	// state and outputs
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_reg              <= ABS_ST_START;
			ata_oe_out             <= 1'b0;
			addr_oe_out            <= 1'b0;
			ata_ctl_out            <= '1;
			ata_engine_run_out     <= 1'b0;
			ata_engine_restart_out <= 1'b0;
			usb_dp_line_pullup_out <= 1'b1; // RQ8
			usb_connect_out        <= 1'b0;
			ser_clk_out            <= 1'b1;
			ser_dat_out            <= 1'b1;
		end else begin
			state_reg              <= state_next;
			ata_oe_out             <= oe_next; // RQ1
			addr_oe_out            <= oe_next && addr_ok_reg; // RQ10
			ata_ctl_out            <= ata_next;
			ata_engine_run_out     <= (state_next == ABS_ST_RUN); // RQ2
			ata_engine_restart_out <= (state_next == ABS_ST_RUN) && !run_ok; // RQ5
			usb_dp_line_pullup_out <= vb_samp_reg; // RQ9
			usb_connect_out        <= (state_next != ABS_ST_IDLE); // RQ4
			ser_clk_out            <= ser_done_reg ? 1'b1 : ser_clk_in; // RQ11
			ser_dat_out            <= ser_done_reg ? 1'b1 : ser_dat_in; // RQ11
		end
	end

	property p_idle_release;
		@(posedge clk_in) disable iff (!reset_n_in)
		(state_reg == ABS_ST_IDLE) |-> !ata_oe_out && !ata_engine_run_out;
	endproperty
	a_idle_release: assert property (p_idle_release) // RQ1
		else $error("ata pins driven while idle");

	property p_fall_idle;
		@(posedge clk_in) disable iff (!reset_n_in)
		(run_ok && en_fall && !mfg_test_enter_in)
			|=> !usb_connect_out && !ata_oe_out;
	endproperty
	a_fall_idle: assert property (p_fall_idle) // RQ4
		else $error("usb not disconnected after enable fall");

	property p_rise_run;
		@(posedge clk_in) disable iff (!reset_n_in)
		(state_reg == ABS_ST_IDLE && en_rise && !mfg_test_enter_in)
			|=> ata_engine_restart_out && usb_connect_out && ata_oe_out;
	endproperty
	a_rise_run: assert property (p_rise_run) // RQ5
		else $error("no restart after enable rise");

	property p_test_sticky;
		@(posedge clk_in) disable iff (!reset_n_in)
		in_test |=> in_test && $stable(en_samp_reg);
	endproperty
	a_test_sticky: assert property (p_test_sticky) // RQ14
		else $error("test mode left or polling active");

	// vbus poll edge, then one cycle for the sample register
	sequence s_vbus_poll;
		poll_hit ##1 1'b1;
	endsequence

	property p_pullup;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_vbus_poll |=> usb_dp_line_pullup_out == $past(vb_now, 2);
	endproperty
	a_pullup: assert property (p_pullup) // RQ9
		else $error("pullup does not follow vbus");

	property p_addr_delay;
		@(posedge clk_in) disable iff (!reset_n_in)
		!addr_ok_reg |=> !addr_oe_out;
	endproperty
	a_addr_delay: assert property (p_addr_delay) // RQ10
		else $error("address lines driven before delay");

	property p_ser_high;
		@(posedge clk_in) disable iff (!reset_n_in)
		ser_done_reg |=> ser_clk_out && ser_dat_out;
	endproperty
	a_ser_high: assert property (p_ser_high) // RQ11
		else $error("serial lines not held high");

	property p_poll_period;
		@(posedge clk_in) disable iff (!reset_n_in)
		(poll_cnt_reg == POLL_MAX) |=> poll_cnt_reg == '0;
	endproperty
	a_poll_period: assert property (p_poll_period) // RQ3
		else $error("poll counter did not wrap");

	property p_run_enabled;
		@(posedge clk_in) disable iff (!reset_n_in)
		ata_engine_run_out |-> ata_oe_out && en_samp_reg;
	endproperty
	a_run_enabled: assert property (p_run_enabled) // RQ2
		else $error("ata engine runs without bus enable");
endmodule // abs_ctrl

// ===== abs_far_end.sv
module abs_far_end (
	// our pins
	input  wire logic                  ata_oe_in,
	input  wire logic                  addr_oe_in,
	input  wire abs_pkg::abs_ata_out_t ctl_in,
	// other host
	input  wire logic                  other_oe_in,
	input  wire abs_pkg::abs_ata_out_t other_in,
	// resolved lines
	output abs_pkg::abs_ata_out_t      bus_out,
	output logic                       clash_out
);
	import abs_pkg::*;
	wire logic [8:0] mask = {{5{addr_oe_in}}, {4{ata_oe_in}}};
	wire logic [8:0] far  = other_oe_in ? other_in : 9'h1FF;
	// released lines fall to the pull-up level unless the other host drives them
	assign bus_out   = abs_ata_out_t'((ctl_in & mask) | (far & ~mask));
	assign clash_out = other_oe_in & (|mask);
endmodule // abs_far_end

// ===== tb_abs_ctrl.sv
module tb_abs_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import abs_pkg::*;
	localparam int PC = 20;
	logic         clk_in = 1'b0;
	logic         reset_n_in = 1'b0;
	logic         ata_bus_enable_in = 1'b1;
	logic         vbus_present_in = 1'b1;
	logic         mfg_test_enter_in = 1'b0;
	logic         ser_clk_in = 1'b0;
	logic         ser_dat_in = 1'b0;
	logic         other_oe = 1'b0;
	abs_ata_out_t ata_ctl_in = abs_ata_out_t'(9'h0A5);
	abs_ata_out_t ata_ctl_out, bus;
	logic         ata_oe_out, addr_oe_out, ata_engine_run_out, clash;
	logic         ata_engine_restart_out, usb_dp_line_pullup_out;
	logic         usb_connect_out, ser_clk_out, ser_dat_out;
	int           err_count = 0;
	int           compares = 0;
	wire logic [6:0] mon = {ata_engine_restart_out, ser_clk_out,
		addr_oe_out, usb_dp_line_pullup_out, usb_connect_out,
		ata_engine_run_out, ata_oe_out};
	always #25 clk_in = ~clk_in;
	abs_ctrl #(.POLL_CYC(PC), .ADDR_CYC(5), .SER_CYC(10)) u_abs_ctrl (
		.clk_in, .reset_n_in, .ata_bus_enable_in, .vbus_present_in,
		.mfg_test_enter_in, .ata_ctl_in, .ser_clk_in, .ser_dat_in,
		.ata_oe_out, .addr_oe_out, .ata_ctl_out, .ata_engine_run_out,
		.ata_engine_restart_out, .usb_dp_line_pullup_out,
		.usb_connect_out, .ser_clk_out, .ser_dat_out);
	abs_far_end u_abs_far_end (.ata_oe_in(ata_oe_out),
		.addr_oe_in(addr_oe_out), .ctl_in(ata_ctl_out),
		.other_oe_in(other_oe), .other_in(abs_ata_out_t'(9'h000)),
		.bus_out(bus), .clash_out(clash));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic chk(input string n, input logic [8:0] e,
		input logic [8:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// bounded wait for one monitored output to reach a level
	task automatic wt(input int k, input logic v, input int lim);
		for (int i = 0; i < lim && mon[k] !== v; i++) cyc(1);
		chk($sformatf("mon bit %0d", k), {8'h00, v}, {8'h00, mon[k]});
	endtask
	task automatic end_of_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic t_reset;
		reset_n_in = 1'b0;
		cyc(20);
		chk("reset outputs", 9'h028, {2'h0, mon});
		chk("reset ctl", 9'h1FF, ata_ctl_out);
		reset_n_in = 1'b1;
	endtask
	task automatic t_start;
		cyc(3);
		chk("early serial clock", 9'h000, {8'h00, ser_clk_out});
		chk("early addr oe", 9'h000, {8'h00, addr_oe_out});
		chk("early serial data", 9'h000, {8'h00, ser_dat_out});
		chk("early ctl", 9'h005, ata_ctl_out);
		wt(1, 1'b1, 6);
		wt(2, 1'b1, 3);
		wt(4, 1'b1, 8);
		chk("bus", 9'h0A5, bus);
		wt(5, 1'b1, 10);
		chk("serial data high", 9'h001, {8'h00, ser_dat_out});
	endtask
	task automatic t_share;
		ata_bus_enable_in = 1'b0;
		wt(1, 1'b0, PC + 6);
		cyc(2);
		other_oe = 1'b1;
		chk("idle outputs", 9'h028, {2'h0, mon[6:0]});
		cyc(2 * PC);
		chk("shared bus", 9'h000, bus);
		chk("clash", 9'h000, {8'h00, clash});
		other_oe = 1'b0;
		ata_bus_enable_in = 1'b1;
		wt(6, 1'b1, PC + 6);
		cyc(1);
		chk("restart width", 9'h000, {8'h00, ata_engine_restart_out});
		wt(2, 1'b1, 3);
		wt(1, 1'b1, 3);
	endtask
	task automatic t_vbus;
		vbus_present_in = 1'b0;
		wt(3, 1'b0, PC + 6);
		vbus_present_in = 1'b1;
		wt(3, 1'b1, PC + 6);
	endtask
	task automatic t_mfg;
		mfg_test_enter_in = 1'b1;
		cyc(1);
		mfg_test_enter_in = 1'b0;
		ata_bus_enable_in = 1'b0;
		cyc(3 * PC);
		chk("test connect", 9'h001, {8'h00, usb_connect_out});
		ata_bus_enable_in = 1'b1;
		t_reset();
		wt(1, 1'b1, 6);
	endtask
	initial begin
		t_reset();
		t_start();
		t_share();
		t_vbus();
		t_mfg();
		end_of_test();
	end
	initial begin
		cyc(2000);
		err_count++;
		end_of_test();
	end
endmodule // tb_abs_ctrl
